//--- bench/rbs_rom_model.sv
// mask rom model: combinational read, pattern derived from the address
`timescale 1ns/1ps
module rbs_rom_model (
    // rom side
    input wire logic [14:0] rom_addr_i,
    output logic [7:0] rom_data_o
);
    // folds the block bits in, so a wrong block gives wrong data
    assign rom_data_o = rom_addr_i[7:0] ^ {1'b0, rom_addr_i[14:8]};
endmodule

//--- bench/rbs_top_tb_top.sv
// self-checking bench for the rom bank select block
`timescale 1ns/1ps
module rbs_top_tb_top;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rd_i = 1'b0;
    logic ce = 1'b1;
    logic ce_seen = 1'b0;
    logic [13:0] addr_i = 14'h0;
    logic [1:0] dir_we = 2'h0, dat_we = 2'h0, dir_d = 2'h0, dat_d = 2'h0;
    logic [1:0] dir = 2'h3, dat = 2'h0, tb_pin = 2'h0;
    logic out_lo, out_hi, oe_lo, oe_hi, rom_rd_o, rd_valid_o;
    logic [7:0] rd_data_o, rom_data;
    logic [14:0] rom_addr_o;
    logic [14:0] q_a[$];
    logic [7:0] q_d[$];
    int n_errors = 0, checks = 0, seed = 32'h6a71;
    always #25 sys_clk_i = ~sys_clk_i;
    rbs_top i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce),
        .sel_dir_we_i(dir_we), .sel_dat_we_i(dat_we), .sel_dir_d_i(dir_d),
        .sel_dat_d_i(dat_d), .bank_select_low_bit_i(oe_lo ? out_lo : tb_pin[0]),
        .bank_select_high_bit_i(oe_hi ? out_hi : tb_pin[1]),
        .bank_select_low_bit_o(out_lo), .bank_select_high_bit_o(out_hi),
        .bank_select_low_bit_oe_o(oe_lo), .bank_select_high_bit_oe_o(oe_hi),
        .rd_i(rd_i), .addr_i(addr_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o),
        .rom_data_i(rom_data));
    rbs_rom_model i_rom (.rom_addr_i(rom_addr_o), .rom_data_o(rom_data));
    // ==========================================
    // compare tasks
    task automatic chk_addr(input logic [14:0] got);
        logic [14:0] exp;
        checks++;
        if (q_a.size() == 0) begin
            n_errors++;
            $display("Error at %0t: rom read with no request", $time);
        end else begin
            exp = q_a.pop_front();
            if (got !== exp) begin
                n_errors++;
                $display("Error at %0t: rom addr %h expected %h", $time, got,
                         exp);
            end
        end
    endtask
    task automatic chk_data(input logic [7:0] got);
        logic [7:0] exp;
        checks++;
        if (q_d.size() == 0) begin
            n_errors++;
            $display("Error at %0t: read data with no request", $time);
        end else begin
            exp = q_d.pop_front();
            if (got !== exp) begin
                n_errors++;
                $display("Error at %0t: read data %h expected %h", $time, got,
                         exp);
            end
        end
    endtask
    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask
    // enable as the design saw it at the last rising edge
    always @(posedge sys_clk_i) ce_seen <= ce;
    // outputs settle after the rising edge, so the monitor looks at fall;
    // a frozen edge leaves old results standing, which must not recount
    always @(negedge sys_clk_i) begin
        if (ce_seen && rom_rd_o === 1'b1) chk_addr(rom_addr_o);
        if (ce_seen && rd_valid_o === 1'b1) chk_data(rd_data_o);
    end
    // ==========================================
    // stimulus tasks; select writes hit both bits, as masked single-bit
    // strobes cannot disturb neighbours
    task automatic wr_sel(input logic [1:0] d, input logic [1:0] v);
        dir_we = 2'h3;
        dat_we = 2'h3;
        dir_d = d;
        dat_d = v;
        dir = d;
        dat = v;
        @(negedge sys_clk_i);
        dir_we = 2'h0;
        dat_we = 2'h0;
        repeat (3) @(negedge sys_clk_i);
        chk_pin({oe_hi, oe_lo, out_hi, out_lo}, {d, v});
    endtask
    // back-to-back random fetches; hole reads expect no rom access
    task automatic burst(input int n);
        logic [31:0] r;
        logic [1:0] s;
        logic [14:0] pa;
        for (int k = 0; k < n; k++) begin
            r = $random(seed);
            s = (dir & dat) | (~dir & tb_pin);
            // block two sits above block one, so the chosen block is s + 1
            pa = {r[13] ? 2'(s + 2'h1) : 2'h0, r[12:0]};
            // a quarter of the edges are frozen and take no request
            ce = (r[31:30] != 2'h0);
            rd_i = 1'b1;
            addr_i = r[13:0];
            if (ce && r[13] && s == 2'h3) q_d.push_back(8'hFF);
            else if (ce) begin
                q_a.push_back(pa);
                q_d.push_back(pa[7:0] ^ {1'b0, pa[14:8]});
            end
            @(negedge sys_clk_i);
        end
        ce = 1'b1;
        rd_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        @(negedge sys_clk_i);
        chk_pin({oe_hi, oe_lo, out_hi, out_lo}, 4'hC);
        burst(16);
        $display("test reset state done");
        for (int i = 0; i < 4; i++) begin
            wr_sel(2'h3, i[1:0]);
            burst(16);
        end
        $display("test driven select done");
        for (int i = 0; i < 4; i++) begin
            tb_pin = 2'(i + 1);
            wr_sel(i[1:0], 2'(3 - i));
            burst(12);
        end
        $display("test pin select done");
        // reset again in mid-run: the latches must fall back to block two
        nrst_i = 1'b0;
        dir = 2'h3;
        dat = 2'h0;
        repeat (2) @(negedge sys_clk_i);
        chk_pin({oe_hi, oe_lo, out_hi, out_lo}, 4'hC);
        nrst_i = 1'b1;
        @(negedge sys_clk_i);
        burst(8);
        $display("test mid-run reset done");
        for (int w = 0; w < 10 && (q_a.size() || q_d.size()); w++)
            @(negedge sys_clk_i);
        if (q_a.size() || q_d.size()) begin
            n_errors++;
            $display("Error at %0t: results still missing", $time);
        end
        give_verdict();
    end
endmodule

//--- design/rbs_sel_bit.sv
// one bank-select port bit: direction and output data latch
`timescale 1ns/1ps
module rbs_sel_bit (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // port writes
    input wire logic dir_we_i,
    input wire logic dir_d_i,
    input wire logic dat_we_i,
    input wire logic dat_d_i,
    // pin
    input wire logic pin_i,
    output logic dir_o,
    output logic dat_o,
    output logic val_o
);
    // initialize forces output mode with low data
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dir_o <= 1'b1;
            dat_o <= 1'b0;
        end else if (ce_i) begin
            if (dir_we_i) begin
                dir_o <= dir_d_i;
            end
            if (dat_we_i) begin
                dat_o <= dat_d_i;
            end
        end
    end
    // input mode lets the pin level choose the bank
    assign val_o = dir_o ? dat_o : pin_i;
endmodule

//--- design/rbs_top.sv
// rom bank select: maps 16K logical rom space onto four 8K blocks
`timescale 1ns/1ps
module rbs_top #(
    parameter int LOG_AW = rbs_pkg::RBS_LOG_AW,
    parameter int DW = rbs_pkg::RBS_DW
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // port b writes for bits 2 and 3 (index 0 low, 1 high)
    input wire logic [1:0] sel_dir_we_i,
    input wire logic [1:0] sel_dat_we_i,
    input wire logic [1:0] sel_dir_d_i,
    input wire logic [1:0] sel_dat_d_i,
    // select pins
    input wire logic bank_select_low_bit_i,
    input wire logic bank_select_high_bit_i,
    output logic bank_select_low_bit_o,
    output logic bank_select_high_bit_o,
    output logic bank_select_low_bit_oe_o,
    output logic bank_select_high_bit_oe_o,
    // processor side rom fetch
    input wire logic rd_i,
    input wire logic [LOG_AW-1:0] addr_i,
    output logic [DW-1:0] rd_data_o,
    output logic rd_valid_o,
    // mask rom side
    output logic [rbs_pkg::RBS_PHY_AW-1:0] rom_addr_o,
    output logic rom_rd_o,
    input wire logic [DW-1:0] rom_data_i
);
    // ========================================
    // select port bits
    logic [1:0] dir;
    logic [1:0] dat;
    logic [1:0] sel;
    logic [1:0] pin;
    assign pin = {bank_select_high_bit_i, bank_select_low_bit_i};

    // one latch per select bit keeps both bits identical in behaviour
    for (genvar i = 0; i < 2; i++) begin : g_bit
        rbs_sel_bit u_bit (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .ce_i(ce_i),
            .dir_we_i(sel_dir_we_i[i]),
            .dir_d_i(sel_dir_d_i[i]),
            .dat_we_i(sel_dat_we_i[i]),
            .dat_d_i(sel_dat_d_i[i]),
            .pin_i(pin[i]),
            .dir_o(dir[i]),
            .dat_o(dat[i]),
            .val_o(sel[i])
        );
    end

    // pin drivers registered so outputs come from flops
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bank_select_low_bit_o <= 1'b0;
            bank_select_high_bit_o <= 1'b0;
            bank_select_low_bit_oe_o <= 1'b1;
            bank_select_high_bit_oe_o <= 1'b1;
        end else if (ce_i) begin
            bank_select_low_bit_o <= dat[0];
            bank_select_high_bit_o <= dat[1];
            bank_select_low_bit_oe_o <= dir[0];
            bank_select_high_bit_oe_o <= dir[1];
        end
    end

    // ========================================
    // address mapping
    logic upper;
    logic [1:0] next_bank;
    logic [rbs_pkg::RBS_PHY_AW-1:0] next_addr;
    assign upper = addr_i[rbs_pkg::RBS_HALF_BIT];
    // lower half ignores select bits entirely; block two lives just
    // above block one in the physical map
    assign next_bank = upper ? 2'(sel + 2'h1) : 2'h0;
    assign next_addr = {next_bank,
                        addr_i[rbs_pkg::RBS_HALF_BIT-1:0]};

    // unmapped selection must never reach the rom
    logic hole;
    assign hole = upper && (sel == rbs_pkg::RBS_SEL_NONE);

    // stage 1: drive rom address; remember whether this read is a hole
    logic hole_q;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rom_addr_o <= '0;
            rom_rd_o <= 1'b0;
            hole_q <= 1'b0;
        end else if (ce_i) begin
            rom_addr_o <= next_addr;
            rom_rd_o <= rd_i && !hole;
            hole_q <= rd_i && hole;
        end
    end

    // stage 2: return rom data or all ones for the missing block
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= '0;
            rd_valid_o <= 1'b0;
        end else if (ce_i) begin
            rd_valid_o <= rom_rd_o || hole_q;
            if (hole_q) begin
                rd_data_o <= rbs_pkg::RBS_ALL_ONES;
            end else if (rom_rd_o) begin
                rd_data_o <= rom_data_i;
            end
        end
    end

    // ========================================
    // checks
    // block number field inside the physical address
    localparam int BANK_HI = rbs_pkg::RBS_PHY_AW - 1;
    localparam int BANK_LO = rbs_pkg::RBS_HALF_BIT;

    // ========================================
    // reset checks
    // judged one edge into reset, so the async clear has surely landed
    a_reset_pins: assert property (
        @(posedge sys_clk_i)
        !nrst_i ##1 !nrst_i
        |-> bank_select_low_bit_oe_o && bank_select_high_bit_oe_o
            && !bank_select_low_bit_o && !bank_select_high_bit_o)
        else $error("select pins not reset to driven low");

    // both latches come up as outputs holding zero
    a_reset_latch: assert property (
        @(posedge sys_clk_i)
        !nrst_i ##1 !nrst_i
        |-> dir == rbs_pkg::RBS_DIR_OUT && dat == rbs_pkg::RBS_SEL_RESET)
        else $error("select latches not reset");

    // no fetch may leak out of reset
    a_reset_idle: assert property (
        @(posedge sys_clk_i)
        !nrst_i ##1 !nrst_i |-> !rom_rd_o && !rd_valid_o)
        else $error("fetch active during reset");

    // ========================================
    // select port checks
    // a data strobe lands in its latch at the next edge
    a_dat_write: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && sel_dat_we_i[1] |=> dat[1] == $past(sel_dat_d_i[1]))
        else $error("select data write lost");

    // a direction strobe lands in its latch at the next edge
    a_dir_write: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && sel_dir_we_i[0] |=> dir[0] == $past(sel_dir_d_i[0]))
        else $error("select direction write lost");

    // pin enable trails the direction latch by one flop
    a_pin_follow: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i |=> bank_select_high_bit_oe_o == $past(dir[1]))
        else $error("pin enable not following direction");

    // pin data trails the data latch by one flop
    a_pin_data: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i |=> bank_select_low_bit_o == $past(dat[0]))
        else $error("pin data not following latch");

    // a low enable must freeze the pipeline and both latches
    a_freeze_hold: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        !ce_i |=> $stable(rom_addr_o) && $stable(rom_rd_o)
            && $stable(rd_valid_o) && $stable(rd_data_o)
            && $stable(dir) && $stable(dat))
        else $error("state moved while clock enable low");

    // ========================================
    // fetch path checks
    // lower half never looks at the select bits
    a_low_half_map: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && rd_i && !upper |=> rom_addr_o[BANK_HI:BANK_LO] == 2'h0)
        else $error("lower half not mapped to block one");

    // upper half reads the block one above the select value
    a_upper_map: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && rd_i && upper && !hole |=> rom_rd_o
            && rom_addr_o[BANK_HI:BANK_LO] == 2'($past(sel) + 2'h1))
        else $error("upper half block choice wrong");

    // the hole may park the address anywhere, but never reads block one
    a_upper_only: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && rd_i && upper
        |=> (rom_rd_o && rom_addr_o[BANK_HI:BANK_LO] != 2'h0)
            || (!rom_rd_o && $past(hole)))
        else $error("upper half reached block one");

    // missing block answers all ones two edges later
    a_hole_ones: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && rd_i && hole ##1 ce_i
        |=> rd_valid_o && rd_data_o == rbs_pkg::RBS_ALL_ONES)
        else $error("missing block did not read all ones");

    // missing block never strobes the rom
    a_hole_no_rom: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && hole |=> !rom_rd_o)
        else $error("rom read during missing block");

    // offset inside the block passes through untouched
    a_low_bits: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i |=> rom_addr_o[BANK_LO-1:0] == $past(addr_i[BANK_LO-1:0]))
        else $error("low address bits altered");

    // rom data is returned as it stood one edge after the strobe
    a_rom_data: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && rom_rd_o |=> rd_valid_o && rd_data_o == $past(rom_data_i))
        else $error("rom data not returned");

    // one valid pulse per read, none without one
    a_valid_pulse: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && !rom_rd_o && !hole_q |=> !rd_valid_o)
        else $error("read valid without a read");

    // ========================================
    // cover points
    // main scenarios: top block, hole, low half, pin select, freeze
    c_block4: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        rd_i && upper && sel == 2'h2);
    c_hole: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        rd_i && hole);
    c_low: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        rd_i && !upper && sel == 2'h3);
    c_pin_sel: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        rd_i && upper && dir != rbs_pkg::RBS_DIR_OUT);
    c_frozen: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        rd_i && !ce_i && rom_rd_o);
endmodule

//--- inc/rbs_pkg.sv
// constants for the rom bank select block
// Summary of operation
// - With address bit 13 low the fetch always goes to block one.
// - With bit 13 high, select bits 00/01/10/11 pick block 2/3/4/none.
// - An upper-half read with both select bits high returns all ones.
// - Initialize makes both select bits outputs holding zero.
// - The chosen block shows only in the upper half; others need rewrite.
package rbs_pkg;
    // ========================================
    // address layout
    localparam int RBS_LOG_AW = 14;
    localparam int RBS_PHY_AW = 15;
    localparam int RBS_HALF_BIT = 13;
    localparam int RBS_DW = 8;
    // ========================================
    // reset values and selections
    localparam logic [1:0] RBS_SEL_RESET = 2'h0;
    localparam logic [1:0] RBS_DIR_OUT = 2'h3;
    localparam logic [1:0] RBS_SEL_NONE = 2'h3;
    localparam logic [7:0] RBS_ALL_ONES = 8'hFF;
endpackage
